// ---- inc/cct_consts.vh ----
// register offsets, field positions and reset values of the capture/compare timer
`ifndef CCT_CONSTS_VH
`define CCT_CONSTS_VH
`define CCT_OFF_CTRL 8'h00
`define CCT_OFF_RELOAD 8'h04
`define CCT_OFF_CAPTURE 8'h08
`define CCT_OFF_CMP0 8'h0C
`define CCT_OFF_CMP1 8'h10
`define CCT_OFF_COUNT 8'h14
`define CCT_OFF_STATUS 8'h18
`define CCT_OFF_MASK 8'h1C
`define CCT_OFF_PRESC 8'h20
// control fields
`define CCT_CTRL_RUN 0
`define CCT_CTRL_MODE_LO 1
`define CCT_CTRL_MODE_HI 2
`define CCT_CTRL_RLD_LO 3
`define CCT_CTRL_RLD_HI 4
`define CCT_CTRL_CAP_LO 5
`define CCT_CTRL_CAP_HI 6
`define CCT_CTRL_PWM_EN 7
`define CCT_CTRL_GATE_POL 8
// mode encodings
`define CCT_MODE_TIMER 2'h0
`define CCT_MODE_GATED 2'h1
`define CCT_MODE_COUNT 2'h2
`define CCT_RLD_NONE 2'h0
`define CCT_RLD_OVF 2'h1
`define CCT_RLD_PIN 2'h2
`define CCT_CAP_RISE 2'h0
`define CCT_CAP_FALL 2'h1
`define CCT_CAP_BOTH 2'h2
`define CCT_CAP_SOFT 2'h3
// status bits
`define CCT_ST_OVF 0
`define CCT_ST_TRIG 1
`define CCT_ST_CAP 2
`define CCT_ST_CMP 3
`define CCT_ST_W 4
// reset values
`define CCT_CTRL_RST 9'h000
`define CCT_PRESC_RST 16'h0000
// idle pin levels {gate, trigger, count}: count and trigger rest high, gate closed
`define CCT_PIN_IDLE 3'h3
`define CCT_AXI_OKAY 2'h0
`define CCT_AXI_SLVERR 2'h2
`endif

// ---- verilog/cct_timer.v ----
// capture/compare timer with an axi4-lite register slave
// Summary of operation
// - single 16-bit counter for generation and capture
// - plain mode counts prescaled system clock ticks
// - gated mode counts only while gate permits
// - count mode advances on count pin falling edges
// - reload none, on overflow, or trigger fall
// - capture on rise, fall, both, or write
// - compare makes periodic output and pwm
// - interrupts from overflow, trigger, capture, compare
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cct_consts.vh"
// one register bus, three pins in, two waveforms and an interrupt out
// all pin inputs are asynchronous and pass a two-stage synchroniser
// limitation: pin pulses shorter than one clock may be missed
// the counter is 16 bits wide; the register map is fixed at that width
module cct_timer #(
    parameter CW = 16
) (
    // system clock and asynchronous active-high reset
    input wire clk,
    input wire sys_rst,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pins
    input wire count_input_pin,
    input wire trigger_input_pin,
    input wire gate_input_pin,
    output reg periodic_out,
    output reg pwm_out,
    output wire irq
);
    // software registers
    reg [8:0] ctrl_ff; // run, mode, reload, capture select, pwm, gate polarity
    reg [CW-1:0] reload_ff; // reload value
    reg [CW-1:0] capture_ff; // captured count
    reg [CW-1:0] cmp0_ff; // period compare
    reg [CW-1:0] cmp1_ff; // duty compare
    reg [CW-1:0] count_ff; // the counter
    reg [CW-1:0] presc_ff; // prescale divide minus one
    reg [CW-1:0] pcnt_ff; // prescale counter
    reg [`CCT_ST_W-1:0] status_ff; // sticky event flags
    reg [`CCT_ST_W-1:0] mask_ff; // interrupt enables

    // two-stage synchronisers per pin, then an edge history stage
    // reset to the pins' idle levels so that leaving reset shows no edge
    localparam [2:0] PIN_IDLE = `CCT_PIN_IDLE; // gate, trigger, count
    reg [2:0] sync1_ff; // first stage, read only by second
    reg [2:0] sync2_ff; // synchronised levels
    reg [2:0] hist_ff; // previous synchronised levels
    wire [2:0] pin_raw;
    wire [2:0] rise;
    wire [2:0] fall;
    assign pin_raw = {gate_input_pin, trigger_input_pin, count_input_pin};

    // one synchroniser per pin
    // the history stage makes each edge a one-cycle strobe
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync1_ff[gi] <= PIN_IDLE[gi];
                    sync2_ff[gi] <= PIN_IDLE[gi];
                    hist_ff[gi] <= PIN_IDLE[gi];
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    hist_ff[gi] <= sync2_ff[gi];
                end
            end
            // edges seen once: history moves on the very next cycle
            assign rise[gi] = sync2_ff[gi] & ~hist_ff[gi];
            assign fall[gi] = ~sync2_ff[gi] & hist_ff[gi];
        end
    endgenerate

    // axi write channel: address and data taken in either order
    // each half waits in its holding register for the other; nothing new
    // is taken while a response stands, so one write is in flight at most
    reg aw_got_ff; // address held
    reg w_got_ff; // data held
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    wire wr_do;
    assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_ff & ~s_axi_bvalid;
    assign wr_do = aw_got_ff & w_got_ff & ~s_axi_bvalid;

    // holding flags, latched address and data, and the write response
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CCT_AXI_OKAY;
        end else begin
            // each half is latched on its own handshake
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            // both halves in: retire them and answer
            if (wr_do) begin
                // response once both halves are in
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped or misaligned addresses answer with an error
                s_axi_bresp <= (awaddr_ff > `CCT_OFF_PRESC || awaddr_ff[1:0] != 2'h0) ?
                    `CCT_AXI_SLVERR : `CCT_AXI_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // write decode strobes; byte lanes 0 and 1 hold the 16-bit fields
    // decoded from the latched address, so the master may move awaddr on
    // as soon as its half has been taken
    wire wr_ctrl = wr_do && awaddr_ff == `CCT_OFF_CTRL;
    wire wr_rld = wr_do && awaddr_ff == `CCT_OFF_RELOAD;
    wire wr_cap = wr_do && awaddr_ff == `CCT_OFF_CAPTURE;
    wire wr_c0 = wr_do && awaddr_ff == `CCT_OFF_CMP0;
    wire wr_c1 = wr_do && awaddr_ff == `CCT_OFF_CMP1;
    wire wr_cnt = wr_do && awaddr_ff == `CCT_OFF_COUNT;
    wire wr_st = wr_do && awaddr_ff == `CCT_OFF_STATUS;
    wire wr_msk = wr_do && awaddr_ff == `CCT_OFF_MASK;
    wire wr_psc = wr_do && awaddr_ff == `CCT_OFF_PRESC;

    // merge a write into a 16-bit field by byte enable
    // lanes 2 and 3 carry nothing: every field fits in the low half word
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
        end
    endfunction

    // decoded control fields
    // mode 3 is spare and holds the counter still
    // gate polarity inverts the sense of the synchronised gate level
    wire run = ctrl_ff[`CCT_CTRL_RUN];
    wire [1:0] mode = ctrl_ff[`CCT_CTRL_MODE_HI:`CCT_CTRL_MODE_LO];
    wire [1:0] rld_sel = ctrl_ff[`CCT_CTRL_RLD_HI:`CCT_CTRL_RLD_LO];
    wire [1:0] cap_sel = ctrl_ff[`CCT_CTRL_CAP_HI:`CCT_CTRL_CAP_LO];
    wire gate_ok = sync2_ff[2] ^ ctrl_ff[`CCT_CTRL_GATE_POL];

    // prescaled tick: one pulse every presc+1 clocks
    // the prescaler is shared by timer and gated modes; count mode ignores it
    // and steps on the synchronised count pin instead
    wire tick = (pcnt_ff == presc_ff);
    // counter step enable per mode
    reg cnt_en; // counter advances this cycle
    always @* begin
        case (mode)
            `CCT_MODE_TIMER: cnt_en = run & tick;
            `CCT_MODE_GATED: cnt_en = run & tick & gate_ok;
            `CCT_MODE_COUNT: cnt_en = run & fall[0];
            default: cnt_en = 1'b0;
        endcase
    end

    // events
    // a wrap is seen only on a cycle that would have advanced the counter,
    // so a stopped counter parked at all ones raises no overflow
    wire wrap = cnt_en && count_ff == {CW{1'b1}};
    wire trig_fall = fall[1];
    // pin reload acts only while running, like the trigger flag
    wire pin_rld = rld_sel == `CCT_RLD_PIN && trig_fall && run;
    // capture select picks the trigger pin edge or the software strobe
    reg cap_hit; // capture trigger this cycle
    always @* begin
        case (cap_sel)
            `CCT_CAP_RISE: cap_hit = rise[1];
            `CCT_CAP_FALL: cap_hit = fall[1];
            `CCT_CAP_BOTH: cap_hit = rise[1] | fall[1];
            `CCT_CAP_SOFT: cap_hit = wr_cap & wstrb_ff[0];
            default: cap_hit = 1'b0;
        endcase
    end
    // compare flag is a level while the counter rests on the period value
    wire cmp_hit = run && count_ff == cmp0_ff;

    // counter, prescaler and reload
    // priority: software load, then pin reload, then wrap, then count;
    // a pin reload in the cycle of a wrap wins, so the flag still sets
    // but the counter takes the reload value once, not twice
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= {CW{1'b0}};
            pcnt_ff <= {CW{1'b0}};
        end else begin
            // prescaler idles at zero when stopped
            // a stopped prescaler restarts a full period after run is set
            if (!run || tick)
                pcnt_ff <= {CW{1'b0}};
            else
                pcnt_ff <= pcnt_ff + 1'b1;
            if (wr_cnt)
                count_ff <= merge16(count_ff, wdata_ff, wstrb_ff); // software load wins
            else if (pin_rld)
                count_ff <= reload_ff;
            else if (wrap)
                count_ff <= (rld_sel == `CCT_RLD_OVF) ? reload_ff : {CW{1'b0}};
            else if (cnt_en)
                count_ff <= count_ff + 1'b1;
        end
    end

    // software registers and capture
    // every field takes only the byte lanes that its strobes enable
    // the compare period resets to all ones, the widest waveform period
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= `CCT_CTRL_RST;
            reload_ff <= {CW{1'b0}};
            capture_ff <= {CW{1'b0}};
            cmp0_ff <= {CW{1'b1}};
            cmp1_ff <= {CW{1'b0}};
            presc_ff <= `CCT_PRESC_RST;
            mask_ff <= {`CCT_ST_W{1'b0}};
        end else begin
            // control: lane 0 holds bits 7:0, lane 1 the gate polarity
            if (wr_ctrl) begin
                if (wstrb_ff[0])
                    ctrl_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1])
                    ctrl_ff[8] <= wdata_ff[8];
            end
            if (wr_rld)
                reload_ff <= merge16(reload_ff, wdata_ff, wstrb_ff);
            if (wr_c0)
                cmp0_ff <= merge16(cmp0_ff, wdata_ff, wstrb_ff);
            if (wr_c1)
                cmp1_ff <= merge16(cmp1_ff, wdata_ff, wstrb_ff);
            if (wr_psc)
                presc_ff <= merge16(presc_ff, wdata_ff, wstrb_ff);
            // mask bits sit in lane 0 beside the flags they enable
            if (wr_msk && wstrb_ff[0])
                mask_ff <= wdata_ff[`CCT_ST_W-1:0];
            // capture takes the live count; the write data is discarded
            if (cap_hit)
                capture_ff <= count_ff;
        end
    end

    // sticky flags: hardware set beats write-one-to-clear
    // a clear and a new event in one cycle leave the flag set, so no event
    // is lost to a clear that software issued just before it
    wire [`CCT_ST_W-1:0] ev_set = {cmp_hit, cap_hit, trig_fall & run, wrap};
    wire [`CCT_ST_W-1:0] ev_clr = (wr_st && wstrb_ff[0]) ? wdata_ff[`CCT_ST_W-1:0] : {`CCT_ST_W{1'b0}};
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            status_ff <= {`CCT_ST_W{1'b0}};
        else
            // clear first, then merge in this cycle's events
            status_ff <= (status_ff & ~ev_clr) | ev_set;
    end
    // level interrupt: high while any enabled flag is set
    assign irq = |(status_ff & mask_ff);

    // waveform outputs from compare
    // both outputs are registered so they carry no decode glitches
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            periodic_out <= 1'b0;
            pwm_out <= 1'b0;
        end else begin
            // toggles at the period match, once per counter cycle, so the
            // output period is two full counter cycles from reload to wrap
            if (cmp_hit && cnt_en)
                periodic_out <= ~periodic_out;
            // high while count below duty value
            pwm_out <= ctrl_ff[`CCT_CTRL_PWM_EN] && run && count_ff < cmp1_ff;
        end
    end

    // axi read channel, one access at a time
    // the address is decoded while it is offered and the data latched at
    // the handshake, so rdata stands unchanged until rready
    reg [31:0] rd_mux;
    reg rd_err;
    // a new address is refused while an answer stands
    assign s_axi_arready = ~s_axi_rvalid;
    always @* begin
        rd_mux = 32'h00000000;
        rd_err = 1'b0;
        case (s_axi_araddr)
            `CCT_OFF_CTRL: rd_mux = {23'h000000, ctrl_ff};
            `CCT_OFF_RELOAD: rd_mux = {16'h0000, reload_ff};
            `CCT_OFF_CAPTURE: rd_mux = {16'h0000, capture_ff};
            `CCT_OFF_CMP0: rd_mux = {16'h0000, cmp0_ff};
            `CCT_OFF_CMP1: rd_mux = {16'h0000, cmp1_ff};
            `CCT_OFF_COUNT: rd_mux = {16'h0000, count_ff};
            `CCT_OFF_STATUS: rd_mux = {28'h0000000, status_ff};
            `CCT_OFF_MASK: rd_mux = {28'h0000000, mask_ff};
            `CCT_OFF_PRESC: rd_mux = {16'h0000, presc_ff};
            default: rd_err = 1'b1; // unmapped
        endcase
    end
    // read answer: latched at the handshake, retired by rready
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CCT_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_err ? `CCT_AXI_SLVERR : `CCT_AXI_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // cct_timer
`default_nettype wire

// ---- tb/cct_pin_model.sv ----
// behavioural model of the external count, trigger and gate pins
`timescale 1ns/10ps
`default_nettype none
module cct_pin_model (
    input wire logic clk,
    output logic count_input_pin,
    output logic trigger_input_pin,
    output logic gate_input_pin
);
    // idle levels: count and trigger rest high, gate closed
    initial begin
        count_input_pin = 1'b1;
        trigger_input_pin = 1'b1;
        gate_input_pin = 1'b0;
    end
    // one pin change after an edge, then room for the synchroniser
    task automatic drive(input int sel, input logic v);
        @(posedge clk);
        case (sel)
            0: count_input_pin <= v;
            1: trigger_input_pin <= v;
            default: gate_input_pin <= v;
        endcase
        repeat (5) @(posedge clk);
    endtask
    // whole low-high cycles, each one falling edge on the count pin
    task automatic pulse_cnt(input int n);
        repeat (n) begin
            drive(0, 1'b0);
            drive(0, 1'b1);
        end
    endtask
endmodule // cct_pin_model
`default_nettype wire

// ---- tb/cct_chk_sva.sv ----
// bus handshake and interrupt checker for the timer
`timescale 1ns/10ps
`default_nettype none
module cct_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not held");
    property p_wblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wblk: assert property (p_wblk) else $error("write accepted while answer pending");
    property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rblk: assert property (p_rblk) else $error("read accepted while answer pending");
    // both halves taken at one edge: the answer is set at the next edge
    property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write answer late");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdone: assert property (p_bdone) else $error("write answer not retired");
    property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdone: assert property (p_rdone) else $error("read answer not retired");
    // irq only drops through a status clear or mask write
    property p_irqfall; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
    a_irqfall: assert property (p_irqfall) else $error("irq fell without a write");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd_stall: cover property (s_axi_rvalid && !s_axi_rready);
    c_irq: cover property ($rose(irq));
endmodule // cct_chk
bind cct_timer cct_chk chk_u (.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// ---- tb/tb_capture_compare_timer.sv ----
// testbench driving the timer over axi4-lite with pin stimulus
`timescale 1ns/10ps
`default_nettype none
`include "cct_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_capture_compare_timer;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd, frozen;
    logic per_prev;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] last_resp, bresp, rresp;
    wire awready, wready, bvalid, arready, rvalid, cnt_pin, trg_pin, gate_pin, per_o, pwm_o, irq;
    wire [31:0] rdata;
    int num_errors = 0, compares = 0, stall = 0, tog, hi, lo;
    // 100 MHz clock
    always #5 clk = ~clk;
    cct_timer dut_u (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .count_input_pin(cnt_pin),
        .trigger_input_pin(trg_pin), .gate_input_pin(gate_pin), .periodic_out(per_o), .pwm_out(pwm_o),
        .irq(irq));
    cct_pin_model pin_u (.clk(clk), .count_input_pin(cnt_pin), .trigger_input_pin(trg_pin),
        .gate_input_pin(gate_pin));
    // write; stall delays bready to exercise the held answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (stall == 0);
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n >= stall) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 200);
        bready <= 1'b0;
        last_resp = bresp;
        if (n >= 200) `CHK(n, 0)
    endtask
    // read, same stall handling on rready
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (stall == 0);
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n >= stall) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 200);
        rready <= 1'b0;
        d = rdata;
        last_resp = rresp;
        if (n >= 200) `CHK(n, 0)
    endtask
    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: 50,000 cycles, far beyond the expected run
    initial begin
        #500000;
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(`CCT_OFF_CMP0, rd); `CHK(rd, 32'h0000FFFF)
        stall = 3;
        axi_rd(`CCT_OFF_CTRL, rd); `CHK(rd, 32'h00000000)
        axi_wr(8'h24, 32'h1); `CHK(last_resp, `CCT_AXI_SLVERR)
        stall = 0;
        axi_rd(8'h24, rd); `CHK(last_resp, `CCT_AXI_SLVERR)
        $display("test reset and map done");
        axi_wr(`CCT_OFF_RELOAD, 32'h1234);
        axi_wr(`CCT_OFF_COUNT, 32'hFFFD);
        axi_wr(`CCT_OFF_CTRL, 32'h9);
        repeat (10) @(posedge clk);
        axi_wr(`CCT_OFF_CTRL, 32'h0);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd >= 32'h1234 && rd < 32'h1260, 1'b1)
        axi_rd(`CCT_OFF_STATUS, rd); `CHK(rd[0], 1'b1)
        axi_wr(`CCT_OFF_MASK, 32'h1); `CHK(irq, 1'b1)
        axi_wr(`CCT_OFF_STATUS, 32'hF); `CHK(irq, 1'b0)
        $display("test overflow reload and irq done");
        axi_wr(`CCT_OFF_COUNT, 32'h0);
        axi_wr(`CCT_OFF_CTRL, 32'h5);
        pin_u.pulse_cnt(5);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd, 32'h5)
        axi_wr(`CCT_OFF_COUNT, 32'h0);
        axi_wr(`CCT_OFF_CTRL, 32'h3);
        repeat (20) @(posedge clk);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd, 32'h0)
        pin_u.drive(2, 1'b1);
        repeat (20) @(posedge clk);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd > 32'h0, 1'b1)
        // inverted gate polarity closes the open gate: count freezes
        axi_wr(`CCT_OFF_CTRL, 32'h103);
        axi_rd(`CCT_OFF_COUNT, frozen);
        repeat (20) @(posedge clk);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd, frozen)
        // no reload: wrap goes to zero although reload holds 1234
        axi_wr(`CCT_OFF_COUNT, 32'hFFFE);
        axi_wr(`CCT_OFF_CTRL, 32'h1);
        axi_wr(`CCT_OFF_CTRL, 32'h0);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd < 32'h10, 1'b1)
        $display("test count and gate done");
        axi_wr(`CCT_OFF_PRESC, 32'hFFFF);
        axi_wr(`CCT_OFF_RELOAD, 32'h77);
        axi_wr(`CCT_OFF_COUNT, 32'h10);
        axi_wr(`CCT_OFF_CTRL, 32'h11);
        pin_u.drive(1, 1'b0);
        axi_rd(`CCT_OFF_COUNT, rd); `CHK(rd == 32'h77 || rd == 32'h78, 1'b1)
        axi_rd(`CCT_OFF_STATUS, rd); `CHK(rd[1], 1'b1)
        pin_u.drive(1, 1'b1);
        $display("test pin reload done");
        // one pass per capture source, counter stopped
        for (int m = 0; m < 4; m++) begin
            axi_wr(`CCT_OFF_CTRL, 32'(m) << 5);
            axi_wr(`CCT_OFF_STATUS, 32'hF);
            axi_wr(`CCT_OFF_COUNT, 32'hA0 + 32'(m));
            if (m == 3) axi_wr(`CCT_OFF_CAPTURE, 32'h0);
            else pin_u.drive(1, 1'b0);
            if (m == 0) pin_u.drive(1, 1'b1);
            axi_rd(`CCT_OFF_CAPTURE, rd); `CHK(rd, 32'hA0 + 32'(m))
            axi_rd(`CCT_OFF_STATUS, rd); `CHK(rd[2], 1'b1)
            pin_u.drive(1, 1'b1);
        end
        $display("test capture done");
        axi_wr(`CCT_OFF_PRESC, 32'h0);
        axi_wr(`CCT_OFF_RELOAD, 32'hFFC0);
        axi_wr(`CCT_OFF_CMP0, 32'hFFE0);
        axi_wr(`CCT_OFF_CMP1, 32'hFFF0);
        axi_wr(`CCT_OFF_COUNT, 32'hFFC0);
        axi_wr(`CCT_OFF_CTRL, 32'h89);
        tog = 0;
        hi = 0;
        lo = 0;
        // sample the waveform outputs away from the clock edge
        @(negedge clk);
        per_prev = per_o;
        repeat (300) begin
            @(negedge clk);
            tog += (per_o !== per_prev);
            per_prev = per_o;
            hi += (pwm_o === 1'b1);
            lo += (pwm_o === 1'b0);
        end
        // 64-count counter cycle: one toggle per cycle, 48 of 64 counts high
        `CHK(tog >= 4 && tog <= 5, 1'b1)
        `CHK(hi >= 215 && hi <= 240 && hi + lo == 300, 1'b1)
        axi_rd(`CCT_OFF_STATUS, rd); `CHK(rd[3], 1'b1)
        $display("test compare and pwm done");
        print_verdict();
    end
endmodule // tb_capture_compare_timer
`default_nettype wire
